// ==== hdl/mtl_alarm_track.sv ====
`timescale 1ns/100ps
module mtl_alarm_track
  import mtl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic out_band,
  input wire logic [23:0] stamp,
  // readback
  input wire logic [3:0] rd_entry,
  output mtl_alarm_s rd_rec
);
  mtl_alarm_s rec_ff [ALM_ENTRIES];
  logic [3:0] ptr_ff;
  logic [3:0] nxt_ptr;
  logic active_ff;
  logic nxt_active;
  logic open_new;
  logic bump;

  // ------------------------------------------------------------
  // entry control
  // ------------------------------------------------------------
  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_active = active_ff;
    open_new = 1'b0;
    bump = 1'b0;
    if (clear) begin
      nxt_ptr = 4'h0;
      nxt_active = 1'b0;
    end else if (step) begin
      if (!out_band) begin
        nxt_active = 1'b0;
      end else if (!active_ff ||
                   rec_ff[ptr_ff - 4'h1].dur == DUR_MAX) begin
        // full table: flag still sets upstream, no record
        if (ptr_ff < 4'(ALM_ENTRIES)) begin
          open_new = 1'b1;
          nxt_ptr = ptr_ff + 4'h1;
          nxt_active = 1'b1;
        end else begin
          nxt_active = 1'b0;
        end
      end else begin
        bump = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_ff <= 4'h0;
      active_ff <= 1'b0;
    end else begin
      ptr_ff <= nxt_ptr;
      active_ff <= nxt_active;
    end
  end

  // ------------------------------------------------------------
  // record storage
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      for (int i = 0; i < ALM_ENTRIES; i++) begin
        rec_ff[i] <= '0;
      end
    end else if (open_new) begin
      rec_ff[ptr_ff] <= '{stamp: stamp, dur: 8'h01};
    end else if (bump) begin
      rec_ff[ptr_ff - 4'h1].dur <= rec_ff[ptr_ff - 4'h1].dur + 8'h01;
    end
  end

  assign rd_rec = (rd_entry < 4'(ALM_ENTRIES)) ? rec_ff[rd_entry] : '0;

  AST_NEW_STAMP: assert property (@(posedge clk) disable iff (rst)
    open_new |=> rec_ff[$past(ptr_ff)].stamp == $past(stamp))
    else $error("alarm stamp not captured");
  AST_PTR_BOUND: assert property (@(posedge clk) disable iff (rst)
    ptr_ff <= 4'(ALM_ENTRIES))
    else $error("alarm pointer past table");
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    (step && !out_band && !clear) |=> !active_ff)
    else $error("duration not frozen");
endmodule

// ==== hdl/mtl_histogram.sv ====
`timescale 1ns/100ps
module mtl_histogram
  import mtl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // update
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] code,
  // readback
  input wire logic [5:0] rd_bin,
  output logic [15:0] rd_count
);
  logic [15:0] bin_ff [HIST_BINS];
  logic [5:0] sel;

  assign sel = code[7:2];

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      for (int i = 0; i < HIST_BINS; i++) begin
        bin_ff[i] <= 16'h0000;
      end
    end else if (step && bin_ff[sel] != BIN_MAX) begin
      bin_ff[sel] <= bin_ff[sel] + 16'h0001;
    end
  end

  assign rd_count = (rd_bin < 6'(HIST_BINS)) ? bin_ff[rd_bin] : 16'h0000;

  AST_SATURATE: assert property (@(posedge clk) disable iff (rst)
    (step && !clear && bin_ff[sel] == BIN_MAX) |=>
      bin_ff[$past(sel)] == BIN_MAX)
    else $error("histogram bin wrapped");
  AST_BIN_INC: assert property (@(posedge clk) disable iff (rst)
    (step && !clear && bin_ff[sel] != BIN_MAX) |=>
      bin_ff[$past(sel)] == $past(bin_ff[sel]) + 16'h0001)
    else $error("histogram bin missed a sample");
endmodule

// ==== hdl/mtl_logger.sv ====
`timescale 1ns/100ps
module mtl_logger
  import mtl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mission control
  input wire logic mission_active,
  input wire logic mem_clear,
  // converter
  input wire logic sample_valid,
  input mtl_sample_s sample,
  output logic sample_ready,
  // memory port from the serial side
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // search
  output logic search_match
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] log_mem [LOG_DEPTH];
  logic [7:0] high_thr_ff, nxt_high_thr;
  logic [7:0] low_thr_ff, nxt_low_thr;
  logic [7:0] control_ff, nxt_control;
  logic high_flag_ff, nxt_high_flag;
  logic low_flag_ff, nxt_low_flag;
  logic [23:0] mission_cnt_ff, nxt_mission_cnt;
  logic [23:0] life_cnt_ff, nxt_life_cnt;
  logic [10:0] wr_ptr_ff, nxt_wr_ptr;
  logic log_full_ff, nxt_log_full;
  logic [7:0] rdata_ff, nxt_rdata;
  logic step;
  logic [7:0] code;
  logic is_high, is_low;
  logic log_we;
  logic [15:0] hist_count;
  mtl_alarm_s low_rec, high_rec;
  logic [15:0] hist_off, alm_off;
  logic in_high_alm;

  // every sample is absorbed in the cycle it is offered
  assign sample_ready = 1'b1;
  assign step = sample_valid && mission_active;

  // ------------------------------------------------------------
  // clamp and compare
  // ------------------------------------------------------------
  always_comb begin
    code = sample.code;
    if (sample.under) begin
      code = CODE_MIN;
    end else if (sample.over || sample.code > CODE_MAX) begin
      code = CODE_MAX;
    end
  end

  assign is_high = code >= high_thr_ff;
  assign is_low = code <= low_thr_ff;

  // ------------------------------------------------------------
  // sample update and register writes
  // ------------------------------------------------------------
  always_comb begin
    nxt_high_thr = high_thr_ff;
    nxt_low_thr = low_thr_ff;
    nxt_control = control_ff;
    nxt_high_flag = high_flag_ff;
    nxt_low_flag = low_flag_ff;
    nxt_mission_cnt = mission_cnt_ff;
    nxt_life_cnt = life_cnt_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_log_full = log_full_ff;
    log_we = 1'b0;
    if (mem_wr) begin
      if (mem_addr == ADR_HIGH_THR) begin
        nxt_high_thr = mem_wdata;
      end else if (mem_addr == ADR_LOW_THR) begin
        nxt_low_thr = mem_wdata;
      end else if (mem_addr == ADR_CONTROL) begin
        nxt_control = mem_wdata;
      end else if (mem_addr == ADR_STATUS) begin
        // only a zero clears; writing one does nothing
        if (!mem_wdata[ST_HIGH_BIT]) begin
          nxt_high_flag = 1'b0;
        end
        if (!mem_wdata[ST_LOW_BIT]) begin
          nxt_low_flag = 1'b0;
        end
      end
    end
    if (mem_clear) begin
      nxt_mission_cnt = 24'h000000;
      nxt_wr_ptr = 11'h000;
      nxt_log_full = 1'b0;
    end else if (step) begin
      nxt_mission_cnt = mission_cnt_ff + 24'h000001;
      // placed after the clear so a same-cycle alarm wins
      if (is_high) begin
        nxt_high_flag = 1'b1;
      end
      if (is_low) begin
        nxt_low_flag = 1'b1;
      end
      if (!log_full_ff) begin
        log_we = 1'b1;
        nxt_wr_ptr = wr_ptr_ff + 11'h001;
        if (wr_ptr_ff == 11'(LOG_DEPTH - 1) && !control_ff[CT_RO_BIT]) begin
          nxt_log_full = 1'b1;
        end
      end
    end
    if (step) begin
      nxt_life_cnt = life_cnt_ff + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_thr_ff <= RST_BYTE;
      low_thr_ff <= RST_BYTE;
      control_ff <= RST_BYTE;
      high_flag_ff <= 1'b0;
      low_flag_ff <= 1'b0;
      mission_cnt_ff <= 24'h000000;
      life_cnt_ff <= 24'h000000;
      wr_ptr_ff <= 11'h000;
      log_full_ff <= 1'b0;
      rdata_ff <= RST_BYTE;
    end else begin
      high_thr_ff <= nxt_high_thr;
      low_thr_ff <= nxt_low_thr;
      control_ff <= nxt_control;
      high_flag_ff <= nxt_high_flag;
      low_flag_ff <= nxt_low_flag;
      mission_cnt_ff <= nxt_mission_cnt;
      life_cnt_ff <= nxt_life_cnt;
      wr_ptr_ff <= nxt_wr_ptr;
      log_full_ff <= nxt_log_full;
      rdata_ff <= nxt_rdata;
    end
  end

  // datalog array has no reset; unwritten bytes read undefined
  always_ff @(posedge clk) begin
    if (log_we) begin
      log_mem[wr_ptr_ff] <= code;
    end
  end

  // ------------------------------------------------------------
  // histogram and alarm trackers
  // ------------------------------------------------------------
  assign hist_off = mem_addr - ADR_HIST;
  assign alm_off = mem_addr - (in_high_alm ? ADR_ALM_HIGH : ADR_ALM_LOW);
  assign in_high_alm = mem_addr >= ADR_ALM_HIGH;

  mtl_histogram u_hist (
    .clk(clk),
    .rst(rst),
    .clear(mem_clear),
    .step(step),
    .code(code),
    .rd_bin(hist_off[6:1]),
    .rd_count(hist_count)
  );

  mtl_alarm_track u_alm_low (
    .clk(clk),
    .rst(rst),
    .clear(mem_clear),
    .step(step),
    .out_band(is_low),
    .stamp(nxt_mission_cnt),
    .rd_entry(alm_off[5:2]),
    .rd_rec(low_rec)
  );

  mtl_alarm_track u_alm_high (
    .clk(clk),
    .rst(rst),
    .clear(mem_clear),
    .step(step),
    .out_band(is_high),
    .stamp(nxt_mission_cnt),
    .rd_entry(alm_off[5:2]),
    .rd_rec(high_rec)
  );

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  always_comb begin
    mtl_alarm_s rec;
    rec = in_high_alm ? high_rec : low_rec;
    nxt_rdata = rdata_ff;
    if (mem_rd) begin
      nxt_rdata = RST_BYTE;
      if (mem_addr == ADR_HIGH_THR) begin
        nxt_rdata = high_thr_ff;
      end else if (mem_addr == ADR_LOW_THR) begin
        nxt_rdata = low_thr_ff;
      end else if (mem_addr == ADR_CONTROL) begin
        nxt_rdata = control_ff;
      end else if (mem_addr == ADR_STATUS) begin
        nxt_rdata[ST_HIGH_BIT] = high_flag_ff;
        nxt_rdata[ST_LOW_BIT] = low_flag_ff;
      end else if (mem_addr == ADR_MCNT_LO) begin
        nxt_rdata = mission_cnt_ff[7:0];
      end else if (mem_addr == ADR_MCNT_CE) begin
        nxt_rdata = mission_cnt_ff[15:8];
      end else if (mem_addr == ADR_MCNT_HI) begin
        nxt_rdata = mission_cnt_ff[23:16];
      end else if (mem_addr == ADR_LCNT_LO) begin
        nxt_rdata = life_cnt_ff[7:0];
      end else if (mem_addr == ADR_LCNT_CE) begin
        nxt_rdata = life_cnt_ff[15:8];
      end else if (mem_addr == ADR_LCNT_HI) begin
        nxt_rdata = life_cnt_ff[23:16];
      end else if (mem_addr >= ADR_ALM_LOW && mem_addr <= ADR_ALM_END) begin
        case (alm_off[1:0])
          2'h0: nxt_rdata = rec.stamp[7:0];
          2'h1: nxt_rdata = rec.stamp[15:8];
          2'h2: nxt_rdata = rec.stamp[23:16];
          default: nxt_rdata = rec.dur;
        endcase
      end else if (mem_addr >= ADR_HIST && mem_addr <= ADR_HIST_END) begin
        nxt_rdata = hist_off[0] ? hist_count[15:8] : hist_count[7:0];
      end else if (mem_addr >= ADR_LOG && mem_addr <= ADR_LOG_END) begin
        nxt_rdata = log_mem[mem_addr[10:0]];
      end
    end
  end

  assign mem_rdata = rdata_ff;
  assign search_match = (control_ff[CT_SRCH_HIGH_BIT] && high_flag_ff) ||
                        (control_ff[CT_SRCH_LOW_BIT] && low_flag_ff);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_sample;
    step && !mem_clear;
  endsequence

  AST_LIFE_COUNT: assert property (@(posedge clk) disable iff (rst)
    step |=> life_cnt_ff == $past(life_cnt_ff) + 24'h000001)
    else $error("lifetime count did not advance");
  AST_LIFE_HOLD: assert property (@(posedge clk) disable iff (rst)
    !step |=> life_cnt_ff == $past(life_cnt_ff))
    else $error("lifetime count changed without sample");
  AST_CLEAR_MCNT: assert property (@(posedge clk) disable iff (rst)
    mem_clear |=> mission_cnt_ff == 24'h000000)
    else $error("mission count not cleared");
  AST_LOG_STOP: assert property (@(posedge clk) disable iff (rst)
    log_full_ff |-> !log_we)
    else $error("datalog written after full");
  AST_WRAP: assert property (@(posedge clk) disable iff (rst)
    (s_sample and (wr_ptr_ff == 11'h7FF && control_ff[CT_RO_BIT] &&
      !log_full_ff)) |=> wr_ptr_ff == 11'h000 && !log_full_ff)
    else $error("datalog did not wrap");
  AST_HIGH_FLAG: assert property (@(posedge clk) disable iff (rst)
    (s_sample and is_high) |=> high_flag_ff)
    else $error("high flag not set");
  AST_LOW_FLAG: assert property (@(posedge clk) disable iff (rst)
    (s_sample and is_low) |=> low_flag_ff)
    else $error("low flag not set");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (mem_wr && mem_addr == ADR_STATUS && !mem_wdata[ST_HIGH_BIT] &&
      !(step && !mem_clear && is_high)) |=> !high_flag_ff)
    else $error("high flag not cleared");
  // idle bus may show both range bits; under takes priority then
  AST_CLAMP: assert property (@(posedge clk) disable iff (rst)
    (sample.over && !sample.under) |-> code == CODE_MAX)
    else $error("reading not clamped");
  AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
    s_sample |=> mission_cnt_ff == $past(mission_cnt_ff) + 24'h000001)
    else $error("sample not absorbed in one cycle");
endmodule

// ==== hdl/mtl_pkg.sv ====
package mtl_pkg;
  // ------------------------------------------------------------
  // memory map
  // ------------------------------------------------------------
  localparam logic [15:0] ADR_HIGH_THR = 16'h020B;
  localparam logic [15:0] ADR_LOW_THR = 16'h020C;
  localparam logic [15:0] ADR_CONTROL = 16'h020E;
  localparam logic [15:0] ADR_STATUS = 16'h0214;
  localparam logic [15:0] ADR_MCNT_LO = 16'h021A;
  localparam logic [15:0] ADR_MCNT_CE = 16'h021B;
  localparam logic [15:0] ADR_MCNT_HI = 16'h021C;
  localparam logic [15:0] ADR_LCNT_LO = 16'h021D;
  localparam logic [15:0] ADR_LCNT_CE = 16'h021E;
  localparam logic [15:0] ADR_LCNT_HI = 16'h021F;
  localparam logic [15:0] ADR_ALM_LOW = 16'h0220;
  localparam logic [15:0] ADR_ALM_HIGH = 16'h0250;
  localparam logic [15:0] ADR_ALM_END = 16'h027F;
  localparam logic [15:0] ADR_HIST = 16'h0800;
  localparam logic [15:0] ADR_HIST_END = 16'h087D;
  localparam logic [15:0] ADR_LOG = 16'h1000;
  localparam logic [15:0] ADR_LOG_END = 16'h17FF;
  // ------------------------------------------------------------
  // field positions and sizes
  // ------------------------------------------------------------
  localparam int ST_LOW_BIT = 2;
  localparam int ST_HIGH_BIT = 1;
  localparam int CT_RO_BIT = 3;
  localparam int CT_SRCH_HIGH_BIT = 1;
  localparam int CT_SRCH_LOW_BIT = 2;
  localparam int LOG_DEPTH = 2048;
  localparam int HIST_BINS = 63;
  localparam int ALM_ENTRIES = 12;
  localparam int ALM_ENTRY_BYTES = 4;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFA;
  localparam logic [15:0] BIN_MAX = 16'hFFFF;
  localparam logic [7:0] DUR_MAX = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // one converted sample from the temperature core
  typedef struct packed {
    logic under;
    logic over;
    logic [7:0] code;
  } mtl_sample_s;

  // one alarm record
  typedef struct packed {
    logic [23:0] stamp;
    logic [7:0] dur;
  } mtl_alarm_s;
endpackage

// ==== sim/mtl_conv_model.sv ====
`timescale 1ns/100ps
module mtl_conv_model
  import mtl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion request from the scheduler side
  input wire logic req,
  input mtl_sample_s req_smp,
  // converter result
  output logic sample_valid,
  output mtl_sample_s sample
);
  logic pend = 1'b0;
  mtl_sample_s pend_smp = '0;

  always @(posedge clk) begin
    pend <= req && !rst;
    pend_smp <= req_smp;
  end

  // result lasts one cycle; outside it the bus toggles, never holds
  always @(negedge clk) begin
    sample_valid <= pend;
    if (pend) begin
      sample <= pend_smp;
    end else begin
      sample <= ~sample;
    end
  end

  initial begin
    sample_valid = 1'b0;
    sample = '0;
  end
endmodule

// ==== sim/tb_mission_temperature_logger.sv ====
`timescale 1ns/100ps
module tb_mission_temperature_logger;
  import mtl_pkg::*;
  // ------------------------------------------------------------
  // signals and reference state
  // ------------------------------------------------------------
  logic clk = 0, rst = 1, mact = 0, mclr = 0, req = 0;
  logic svld, srdy, mrd = 0, mwr = 0, smatch;
  mtl_sample_s req_smp = '0, smp;
  logic [15:0] madr = '0;
  logic [7:0] mwd = '0, mrdata, ctl = 0, hthr = 0, lthr = 0;
  int err_total = 0, checks = 0;
  int mcnt = 0, lcnt = 0, lptr = 0, hist[63], rptr[2];
  logic [7:0] rlog[2048];
  bit [7:0] rdur[2][12];
  bit [23:0] stmp[2][12];
  bit rlw[2048], ract[2], fl[2];
  logic [7:0] cor[6] = '{8'h30, 8'h31, 8'hBF, 8'hC0, 8'hFA, 8'hFB};

  mtl_conv_model CONV (.clk(clk), .rst(rst), .req(req),
    .req_smp(req_smp), .sample_valid(svld), .sample(smp));

  mtl_logger DUT (.clk(clk), .rst(rst), .mission_active(mact),
    .mem_clear(mclr), .sample_valid(svld), .sample(smp),
    .sample_ready(srdy), .mem_addr(madr), .mem_rd(mrd), .mem_wr(mwr),
    .mem_wdata(mwd), .mem_rdata(mrdata), .search_match(smatch));

  initial begin
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // expectation model
  // ------------------------------------------------------------
  function automatic logic [7:0] clampf(mtl_sample_s s);
    if (s.under) return CODE_MIN;
    if (s.over || s.code > CODE_MAX) return CODE_MAX;
    return s.code;
  endfunction

  task automatic ref_step(input logic [7:0] c);
    int p, k;
    bit hit;
    mcnt++;
    lcnt++;
    if (ctl[CT_RO_BIT] || lptr < LOG_DEPTH) begin
      rlog[lptr % LOG_DEPTH] = c;
      rlw[lptr % LOG_DEPTH] = 1;
      lptr++;
    end
    if (hist[c >> 2] < 65535) hist[c >> 2]++;
    for (p = 0; p < 2; p++) begin
      hit = p ? (c >= hthr) : (c <= lthr);
      k = rptr[p] - 1;
      if (hit) fl[p] = 1;
      if (!hit) ract[p] = 0;
      else if (ract[p] && rdur[p][k] != DUR_MAX) rdur[p][k]++;
      else if (rptr[p] < ALM_ENTRIES) begin
        stmp[p][rptr[p]] = 24'(mcnt);
        rdur[p][rptr[p]] = 8'h01;
        rptr[p]++;
        ract[p] = 1;
      end else ract[p] = 0;
    end
  endtask

  // log contents survive a clear, only its pointer restarts
  task automatic ref_clear;
    mcnt = 0;
    lptr = 0;
    hist = '{default: 0};
    stmp = '{default: '0};
    rdur = '{default: '0};
    rptr = '{0, 0};
    ract = '{0, 0};
  endtask

  // ------------------------------------------------------------
  // port tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h exp %h adr %h", $time, got, exp, madr);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    madr = a;
    mwd = d;
    mwr = 1;
    @(negedge clk);
    mwr = 0;
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    madr = a;
    mrd = 1;
    @(negedge clk);
    mrd = 0;
    chk(mrdata, exp);
  endtask

  task automatic send(input logic [7:0] c, input logic u, input logic o);
    @(negedge clk);
    req = 1;
    req_smp = {u, o, c};
    if (mact) ref_step(clampf({u, o, c}));
  endtask

  task automatic burst(input int n, input bit hot);
    int r;
    repeat (n) begin
      r = $urandom_range(0, 9);
      if (hot) send(8'($urandom), 1'b0, 1'b1);
      else send(8'($urandom), r == 0, r == 1);
    end
    @(negedge clk);
    req = 0;
    repeat (3) @(negedge clk);
  endtask

  task automatic verify_all(input string name);
    int i, p, e;
    logic [31:0] w;
    for (i = 0; i < 3; i++) begin
      rc(ADR_MCNT_LO + 16'(i), 8'(mcnt >> (8 * i)));
      rc(ADR_LCNT_LO + 16'(i), 8'(lcnt >> (8 * i)));
    end
    for (i = 0; i < HIST_BINS * 2; i++)
      rc(ADR_HIST + 16'(i), 8'(hist[i / 2] >> (8 * (i % 2))));
    for (p = 0; p < 2; p++)
      for (e = 0; e < ALM_ENTRIES * 4; e++) begin
        w = {rdur[p][e / 4], stmp[p][e / 4]};
        rc((p ? ADR_ALM_HIGH : ADR_ALM_LOW) + 16'(e),
          8'(w >> (8 * (e % 4))));
      end
    for (i = 0; i < LOG_DEPTH; i++)
      if (rlw[i]) rc(ADR_LOG + 16'(i), rlog[i]);
    rc(ADR_STATUS, {5'h00, fl[0], fl[1], 1'b0});
    chk({7'h00, smatch}, {7'h00, (ctl[1] & fl[1]) | (ctl[2] & fl[0])});
    $display("test %s done", name);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hDD5D494C));
    repeat (5) @(negedge clk);
    rst = 0;
    chk({7'h00, srdy}, 8'h01);
    wr(ADR_LCNT_LO, 8'h5A);
    rc(16'h0300, 8'h00);
    verify_all("reset");
    hthr = 8'hC0;
    lthr = 8'h30;
    ctl = 8'h06;
    wr(ADR_HIGH_THR, hthr);
    wr(ADR_LOW_THR, lthr);
    wr(ADR_CONTROL, ctl);
    rc(ADR_HIGH_THR, hthr);
    rc(ADR_LOW_THR, lthr);
    // samples outside a mission must leave every count alone
    burst(5, 0);
    mact = 1;
    foreach (cor[i]) send(cor[i], 1'b0, 1'b0);
    burst(300, 0);
    verify_all("random mission");
    burst(65540, 1);
    verify_all("saturation");
    wr(ADR_STATUS, 8'hFF);
    rc(ADR_STATUS, {5'h00, fl[0], fl[1], 1'b0});
    wr(ADR_STATUS, 8'h00);
    fl = '{0, 0};
    rc(ADR_STATUS, 8'h00);
    chk({7'h00, smatch}, 8'h00);
    $display("test flag clear done");
    @(negedge clk);
    mclr = 1;
    @(negedge clk);
    mclr = 0;
    ref_clear();
    verify_all("memory clear");
    ctl = 8'h08;
    wr(ADR_CONTROL, ctl);
    burst(2060, 0);
    verify_all("rollover");
    test_done();
  end

  // full run is near 83k cycles; the limit leaves some slack
  initial begin
    #(95000 * 10);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end
endmodule
